// ==== hw/comparator_status_control.sv ====
// register bank and status logic for a group of comparator/op amp units
//
// Overview of operation
// - clear/set/invert aliases at +4, +8, +c
// - alias writes touch only written implemented ones
// - idle stop bit halts all units in idle
// - status bits 4..0 show comparator outputs
// - reported output follows selected polarity
// - status bits mirror unit output and event
// - unimplemented status bits read as zero
// - four-way inverting input channel select
// - output pin drive gated by enable
// - events follow selected edge of output
// - blanking and divided-rate digital filter
// - mask control picks blanking sources, logic
// - op amp and comparator enabled separately
// - up to eight units, one stand-alone
// - edge codes: none, rise, fall, any
// - set event flag blocks events until cleared
// - filter divide 1 to 128 by code
`timescale 1ns/1ps
`include "cmp_defines.svh"
module comparator_status_control
	import cmp_pkg::*;
#(
	parameter int NUM_UNITS = 5,
	parameter logic [7:0] STANDALONE = 8'h10,
	parameter bit EVT_MIRROR = 1'b0
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [`ADDR_W-1:0] address,
	input wire logic [31:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [31:0] readData,
	input wire logic idleMode,
	input wire logic [NUM_UNITS-1:0] cmpRaw,
	input wire logic [3:0] blankSrc,
	input wire logic [7:0] filtTick,
	output logic [NUM_UNITS-1:0] cmpOutPin,
	output logic [NUM_UNITS-1:0] cmpOutPinOe,
	output logic [NUM_UNITS-1:0] cmpEnable,
	output logic [NUM_UNITS-1:0] opampEnable,
	output logic [NUM_UNITS-1:0] opampOutEnable,
	output logic [NUM_UNITS-1:0] refSelect,
	output logic [2*NUM_UNITS-1:0] invChanSel,
	output logic [NUM_UNITS-1:0] eventTrigger
);
	localparam logic [`ADDR_W-1:0] UNIT_SPAN = `ADDR_W'(NUM_UNITS * 16);

	word_t statusCtl;
	word_t ctrl [NUM_UNITS];
	word_t mask [NUM_UNITS];
	word_t statusWord;
	word_t readValue;
	logic [NUM_UNITS-1:0] unitOut;
	logic [NUM_UNITS-1:0] unitEvt;
	logic [NUM_UNITS-1:0] evtFlag;
	logic [`ADDR_W-1:0] baseAddr;
	logic [`ADDR_W-1:0] ctrlOff;
	logic [`ADDR_W-1:0] maskOff;
	alias_op_e aliasOp;
	logic statusHit;
	logic ctrlHit;
	logic maskHit;
	logic [`ADDR_W-1-`UNIT_SHIFT:0] ctrlIdx;
	logic [`ADDR_W-1-`UNIT_SHIFT:0] maskIdx;
	logic haltAll;

	// merge a bus write into a register through the alias operations
	function automatic word_t aliasWrite(input word_t old, input word_t wd, input alias_op_e op,
		input word_t wm);
		word_t res;
		res = old;
		unique case (op)
			OP_WRITE: res = (old & ~wm) | (wd & wm);
			OP_CLEAR: res = old & ~(wd & wm);
			OP_SET: res = old | (wd & wm);
			OP_INVERT: res = old ^ (wd & wm);
		endcase
		return res;
	endfunction : aliasWrite

	// writable bits of one unit control word; stand-alone units lack op amp bits
	function automatic word_t ctrlMask(input int unsigned idx);
		word_t wm;
		wm = `CTRL_WMASK;
		if (STANDALONE[idx]) begin
			wm = wm & ~`OPAMP_BITS;
		end
		return wm;
	endfunction : ctrlMask

	////////////////////////////////////////////////////////////////////////////
	// address decode: low two word bits pick the alias
	assign aliasOp = alias_op_e'(address[3:2]);
	assign baseAddr = {address[`ADDR_W-1:4], 4'h0};
	assign ctrlOff = baseAddr - `CTRL_BASE;
	assign maskOff = baseAddr - `MASK_BASE;
	assign statusHit = baseAddr == `STATUS_OFS;
	assign ctrlHit = (baseAddr >= `CTRL_BASE) && (ctrlOff < UNIT_SPAN);
	assign maskHit = (baseAddr >= `MASK_BASE) && (maskOff < UNIT_SPAN);
	assign ctrlIdx = ctrlOff[`ADDR_W-1:`UNIT_SHIFT];
	assign maskIdx = maskOff[`ADDR_W-1:`UNIT_SHIFT];
	assign haltAll = idleMode && statusCtl[`IDLE_STOP_BIT];

	////////////////////////////////////////////////////////////////////////////
	// shared status: only the idle stop bit is stored
	// write, clear, set and invert aliases on the status word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			statusCtl <= `REG_RESET;
		end else if (writeStrobe && statusHit) begin
			statusCtl <= aliasWrite(statusCtl, writeData, aliasOp, `STATUS_WMASK);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				mask[i] <= `REG_RESET;
			end
		end else if (writeStrobe && maskHit) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				if (int'(maskIdx) == i) begin
					mask[i] <= aliasWrite(mask[i], writeData, aliasOp, `MASK_WMASK);
				end
			end
		end
	end

	// control words; op amp bits absent on stand-alone units
	// hardware event set placed last so it wins over a clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				ctrl[i] <= `REG_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				if (writeStrobe && ctrlHit && int'(ctrlIdx) == i) begin
					ctrl[i] <= aliasWrite(ctrl[i], writeData, aliasOp, ctrlMask(i));
				end
				if (unitEvt[i]) begin
					ctrl[i][`EVT_BIT] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one channel per unit, up to eight
	genvar g;
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : gUnit
			cmp_unit_if cu ();
			assign cu.on = ctrl[g][`ON_BIT];
			assign cu.invert = ctrl[g][`INV_BIT];
			assign cu.filtEn = ctrl[g][`FILT_EN_BIT];
			assign cu.filtSel = ctrl[g][`FILT_SEL_LSB+:3];
			assign cu.filtDiv = ctrl[g][`FILT_DIV_LSB+:3];
			assign cu.edgeSel = ctrl[g][`EDGE_LSB+:2];
			assign cu.blankSrcEn = mask[g][3:0];
			assign cu.blankAnd = mask[g][`BLANK_AND_BIT];
			assign cu.halt = haltAll;
			assign cu.evtFlag = ctrl[g][`EVT_BIT];
			assign unitOut[g] = cu.outState;
			assign unitEvt[g] = cu.evtPulse;
			assign evtFlag[g] = ctrl[g][`EVT_BIT];

			comparator_unit_channel uChan (
				.clock(clock),
				.reset_n(reset_n),
				.cmpRaw(cmpRaw[g]),
				.blankSrc(blankSrc),
				.filtTick(filtTick),
				.cu(cu)
			);

			// pin driven only when enabled and on
			assign cmpOutPin[g] = cu.outState;
			assign cmpOutPinOe[g] = ctrl[g][`OE_BIT] && ctrl[g][`ON_BIT];
			// independent comparator and op amp enables
			assign cmpEnable[g] = ctrl[g][`ON_BIT] && !haltAll;
			assign opampEnable[g] = ctrl[g][`AMPMOD_BIT] && !haltAll;
			assign opampOutEnable[g] = ctrl[g][`OAO_BIT];
			assign refSelect[g] = ctrl[g][`CREF_BIT];
			assign invChanSel[2*g+:2] = ctrl[g][`CCH_LSB+:2];
			assign eventTrigger[g] = cu.evtPulse;
			// flag holds and blocks events until software writes it
			a_event_sticky: assert property (@(posedge clock) disable iff (!reset_n)
				evtFlag[g] && !(writeStrobe && ctrlHit && int'(ctrlIdx) == g) |=> evtFlag[g] && !eventTrigger[g])
				else $error("event flag dropped or event repeated");
			a_event_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
				eventTrigger[g] |-> !evtFlag[g] ##1 evtFlag[g])
				else $error("trigger did not set event flag");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// outputs in low bits, idle stop at bit 13
	// optional event mirror, off by default
	always_comb begin
		statusWord = '0;
		for (int i = 0; i < NUM_UNITS && i < `STATUS_OUT_BITS; i++) begin
			statusWord[i] = unitOut[i];
			if (EVT_MIRROR) begin
				statusWord[`EVT_MIRROR_LSB+i] = evtFlag[i];
			end
		end
		statusWord[`IDLE_STOP_BIT] = statusCtl[`IDLE_STOP_BIT];
	end

	always_comb begin
		readValue = '0;
		if (aliasOp == OP_WRITE) begin
			if (statusHit) begin
				readValue = statusWord;
			end
			for (int i = 0; i < NUM_UNITS; i++) begin
				if (ctrlHit && int'(ctrlIdx) == i) begin
					readValue = (ctrl[i] & ctrlMask(i)) | (word_t'(unitOut[i]) << `OUT_BIT);
				end
				if (maskHit && int'(maskIdx) == i) begin
					readValue = mask[i];
				end
			end
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			readData <= '0;
		end else begin
			readData <= readStrobe ? readValue : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	a_alias_clear_bit: assert property (
		writeStrobe && address == (`STATUS_OFS | 9'h004) && writeData[`IDLE_STOP_BIT]
		|=> !statusCtl[`IDLE_STOP_BIT])
		else $error("status clear alias did not clear idle stop");
	a_alias_set_mask: assert property (
		writeStrobe && address == (`MASK_BASE | 9'h008) && writeData[0]
		|=> mask[0][0])
		else $error("set alias did not set mask bit");
	a_alias_inv_bit: assert property (
		writeStrobe && address == (`STATUS_OFS | 9'h00c) && writeData[`IDLE_STOP_BIT]
		|=> statusCtl[`IDLE_STOP_BIT] != $past(statusCtl[`IDLE_STOP_BIT]))
		else $error("invert alias did not toggle idle stop");
	a_alias_read_zero: assert property (
		readStrobe && address[3:2] != 2'h0 |=> readData == 32'h00000000)
		else $error("alias read returned data");
	a_status_zero_bits: assert property (
		readStrobe && address == `STATUS_OFS && !EVT_MIRROR
		|=> (readData & `STATUS_ZERO_MASK) == 32'h00000000)
		else $error("unimplemented status bits not zero");
	a_status_out_copy: assert property (
		readStrobe && address == `STATUS_OFS
		|=> readData[0] == $past(unitOut[0]))
		else $error("status output bit does not mirror unit");
	a_idle_halt: assert property (
		idleMode && statusCtl[`IDLE_STOP_BIT] |-> cmpEnable == '0 && eventTrigger == '0)
		else $error("units run while idle stop is active");
	a_pin_gate: assert property (
		!ctrl[0][`OE_BIT] |-> !cmpOutPinOe[0])
		else $error("pin driven while output disabled");
	c_event_seen: cover property ((|eventTrigger) ##[1:20] (writeStrobe && aliasOp == OP_CLEAR));
	c_idle_stop: cover property (haltAll ##1 !haltAll);
	c_filter_change: cover property (ctrl[0][`FILT_EN_BIT] && $rose(unitOut[0]));
endmodule : comparator_status_control

// ==== include/cmp_defines.svh ====
// register offsets, field positions, masks and reset values of the comparator block
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH
`define ADDR_W 9
`define STATUS_OFS 9'h000
`define CTRL_BASE 9'h010
`define MASK_BASE 9'h090
`define UNIT_SHIFT 4
`define REG_RESET 32'h00000000
`define STATUS_WMASK 32'h00002000
`define STATUS_ZERO_MASK 32'hffffdfe0
`define STATUS_OUT_BITS 5
`define IDLE_STOP_BIT 13
`define EVT_MIRROR_LSB 16
`define CTRL_WMASK 32'h007feed3
`define OPAMP_BITS 32'h00000c00
`define MASK_WMASK 32'h0000010f
`define FILT_SEL_LSB 20
`define FILT_EN_BIT 19
`define FILT_DIV_LSB 16
`define ON_BIT 15
`define OE_BIT 14
`define INV_BIT 13
`define OAO_BIT 11
`define AMPMOD_BIT 10
`define EVT_BIT 9
`define OUT_BIT 8
`define EDGE_LSB 6
`define CREF_BIT 4
`define CCH_LSB 0
`define BLANK_AND_BIT 8
`define FILT_TAPS 3
`endif

// ==== include/cmp_pkg.sv ====
// types shared by the comparator control block
package cmp_pkg;
	typedef enum logic [1:0] {OP_WRITE, OP_CLEAR, OP_SET, OP_INVERT} alias_op_e;
	typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_ANY} edge_sel_e;
	typedef logic [31:0] word_t;
endpackage : cmp_pkg

// ==== include/cmp_unit_if.sv ====
// configuration and status carried between the register bank and one comparator channel
`timescale 1ns/1ps
interface cmp_unit_if;
	logic on;
	logic invert;
	logic filtEn;
	logic [2:0] filtSel;
	logic [2:0] filtDiv;
	logic [1:0] edgeSel;
	logic [3:0] blankSrcEn;
	logic blankAnd;
	logic halt;
	logic evtFlag;
	logic outState;
	logic evtPulse;
	modport ctrl (output on, invert, filtEn, filtSel, filtDiv, edgeSel, blankSrcEn, blankAnd, halt, evtFlag,
		input outState, evtPulse);
	modport unit (input on, invert, filtEn, filtSel, filtDiv, edgeSel, blankSrcEn, blankAnd, halt, evtFlag,
		output outState, evtPulse);
endinterface : cmp_unit_if

// ==== hw/comparator_unit_channel.sv ====
// one comparator channel: synchroniser, polarity, blanking, filter and edge events
`timescale 1ns/1ps
`include "cmp_defines.svh"
module comparator_unit_channel
	import cmp_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic cmpRaw,
	input wire logic [3:0] blankSrc,
	input wire logic [7:0] filtTick,
	cmp_unit_if.unit cu
);
	logic rawMeta;
	logic rawSync;
	logic polOut;
	logic blankAct;
	logic srcTick;
	logic sampleTick;
	logic [6:0] divCnt;
	logic [6:0] divMask;
	logic [`FILT_TAPS-1:0] hist;
	logic next_out;
	logic prevOut;
	logic edgeHit;

	////////////////////////////////////////////////////////////////////////////
	// analog result comes from outside the clock domain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rawMeta <= 1'b0;
			rawSync <= 1'b0;
		end else begin
			rawMeta <= cmpRaw;
			rawSync <= rawMeta;
		end
	end

	assign polOut = rawSync ^ cu.invert;

	// blanking window from chosen sources, or/and combine
	assign blankAct = (cu.blankSrcEn != 4'h0) && (cu.blankAnd ? ((blankSrc | ~cu.blankSrcEn) == 4'hf)
		: ((blankSrc & cu.blankSrcEn) != 4'h0));

	////////////////////////////////////////////////////////////////////////////
	// power of two sample divider
	assign srcTick = filtTick[cu.filtSel];
	assign divMask = 7'((8'h01 << cu.filtDiv) - 8'h01);
	assign sampleTick = srcTick && ((divCnt & divMask) == divMask);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			divCnt <= 7'h00;
		end else if (srcTick) begin
			divCnt <= divCnt + 7'h01;
		end
	end

	// sample history for the digital filter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hist <= '0;
		end else if (sampleTick) begin
			hist <= {hist[`FILT_TAPS-2:0], polOut};
		end
	end

	// output held while blanked, changes on agreeing samples
	always_comb begin
		next_out = cu.outState;
		if (!cu.on) begin
			next_out = 1'b0;
		end else if (cu.halt || blankAct) begin
			next_out = cu.outState;
		end else if (!cu.filtEn) begin
			next_out = polOut;
		end else if (&hist) begin
			next_out = 1'b1;
		end else if (~|hist) begin
			next_out = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cu.outState <= 1'b0;
			prevOut <= 1'b0;
		end else begin
			cu.outState <= next_out;
			prevOut <= cu.outState;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge from the output state in successive cycles
	always_comb begin
		edgeHit = 1'b0;
		unique case (edge_sel_e'(cu.edgeSel))
			EDGE_NONE: edgeHit = 1'b0;
			EDGE_RISE: edgeHit = cu.outState & ~prevOut;
			EDGE_FALL: edgeHit = ~cu.outState & prevOut;
			EDGE_ANY: edgeHit = cu.outState ^ prevOut;
		endcase
	end

	// no new event while the flag is set
	assign cu.evtPulse = edgeHit && cu.on && !cu.halt && !cu.evtFlag;
endmodule : comparator_unit_channel

// ==== testbench/tb_top.sv ====
// self-checking bench for the comparator status and control block
`timescale 1ns/1ps
`include "cmp_defines.svh"
module tb_top
	import cmp_pkg::*;
;
	localparam int N = 5;
	localparam word_t ON = 32'h1 << `ON_BIT;
	localparam word_t OE = 32'h1 << `OE_BIT;
	localparam word_t INV = 32'h1 << `INV_BIT;
	localparam word_t EVT = 32'h1 << `EVT_BIT;
	localparam word_t OUTB = 32'h1 << `OUT_BIT;
	localparam word_t FEN = 32'h1 << `FILT_EN_BIT;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [`ADDR_W-1:0] address = '0;
	word_t writeData = '0;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	word_t readData;
	logic idleMode = 1'b0;
	logic [N-1:0] cmpRaw = '0;
	logic [3:0] blankSrc = 4'h0;
	logic [7:0] filtTick = 8'h01;
	logic [N-1:0] cmpOutPin, cmpOutPinOe, cmpEnable, opampEnable, opampOutEnable, refSelect, eventTrigger;
	logic [2*N-1:0] invChanSel;
	int failCount = 0;
	int checked = 0;
	int evtCount = 0;
	int cycles = 0;
	int base;
	word_t v;

	comparator_status_control #(.NUM_UNITS(N)) u_dut (
		.clock(clock), .reset_n(reset_n), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .idleMode(idleMode),
		.cmpRaw(cmpRaw), .blankSrc(blankSrc), .filtTick(filtTick), .cmpOutPin(cmpOutPin),
		.cmpOutPinOe(cmpOutPinOe), .cmpEnable(cmpEnable), .opampEnable(opampEnable),
		.opampOutEnable(opampOutEnable), .refSelect(refSelect), .invChanSel(invChanSel),
		.eventTrigger(eventTrigger)
	);

	// 250 mhz clock
	always #2 clock = ~clock;

	// event pulses of unit 1 and the hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		filtTick <= {6'h00, cycles[1:0] == 2'h0, 1'b1};
		if (eventTrigger[1] === 1'b1)
			evtCount <= evtCount + 1;
		if (cycles == 8000) begin
			failCount = failCount + 1;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus tasks and comparison
	function automatic logic [`ADDR_W-1:0] ctrlAddr(input int u);
		ctrlAddr = `CTRL_BASE + (`ADDR_W'(u) << `UNIT_SHIFT);
	endfunction : ctrlAddr

	task automatic wr(input logic [`ADDR_W-1:0] a, input word_t d);
		@(posedge clock);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [`ADDR_W-1:0] a, output word_t d);
		@(posedge clock);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 d = readData;
	endtask : rd

	task automatic check(input word_t seen, input word_t exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failCount = failCount + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic setRaw(input logic b);
		@(posedge clock);
		cmpRaw[1] <= b;
	endtask : setRaw

	task automatic waitC(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : waitC

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		// status register, its aliases and reserved bits
		rd(`STATUS_OFS, v);
		check(v, `REG_RESET);
		wr(`STATUS_OFS, 32'hffffffff);
		rd(`STATUS_OFS, v);
		check(v, 32'h00002000);
		wr(`STATUS_OFS + 9'h004, 32'hffffffff);
		rd(`STATUS_OFS, v);
		check(v, 32'h00000000);
		wr(`STATUS_OFS + 9'h008, 32'hffffdfff);
		rd(`STATUS_OFS, v);
		check(v, 32'h00000000);
		wr(`STATUS_OFS + 9'h008, 32'h00002000);
		rd(`STATUS_OFS, v);
		check(v, 32'h00002000);
		wr(`STATUS_OFS + 9'h00c, 32'h00002000);
		rd(`STATUS_OFS, v);
		check(v, 32'h00000000);
		rd(`STATUS_OFS + 9'h008, v);
		check(v, 32'h00000000);
		// mask control of unit 0 through its set and clear aliases
		wr(`MASK_BASE + 9'h008, 32'hffffffff);
		rd(`MASK_BASE, v);
		check(v, `MASK_WMASK);
		wr(`MASK_BASE + 9'h004, 32'h00000001);
		rd(`MASK_BASE, v);
		check(v, 32'h0000010e);
		wr(`MASK_BASE, 32'h00000000);
		// control field routing, unit 0 kept off
		wr(ctrlAddr(0), 32'hffff7fff);
		rd(ctrlAddr(0), v);
		check(v, `CTRL_WMASK & ~ON & ~OUTB);
		check(word_t'({refSelect[0], invChanSel[1:0], opampOutEnable[0]}), 32'h0000000f);
		check(word_t'({cmpOutPinOe[0], cmpEnable[0], opampEnable[0]}), 32'h00000001);
		// stand-alone unit: every channel, no op amp
		for (int c = 0; c < 4; c++) begin
			wr(ctrlAddr(4), word_t'(c) | `OPAMP_BITS | (32'h1 << `OAO_BIT));
			check(word_t'({opampOutEnable[4], opampEnable[4], invChanSel[9:8]}), word_t'(c));
		end
		// unmapped place
		wr(`MASK_BASE + 9'h050, 32'hffffffff);
		rd(`MASK_BASE + 9'h050, v);
		check(v, 32'h00000000);
		// rising edge event on unit 1, sticky flag
		base = evtCount;
		wr(ctrlAddr(1), ON | OE | (32'h1 << `EDGE_LSB));
		setRaw(1'b1);
		waitC(8);
		check(word_t'({cmpOutPin[1], cmpOutPinOe[1]}), 32'h00000003);
		check(evtCount - base, 32'h00000001);
		rd(ctrlAddr(1), v);
		check(v, ON | OE | (32'h1 << `EDGE_LSB) | OUTB | EVT);
		rd(`STATUS_OFS, v);
		check(v, 32'h00000002);
		setRaw(1'b0);
		waitC(8);
		setRaw(1'b1);
		waitC(8);
		check(evtCount - base, 32'h00000001);
		// every edge code, flag cleared after each transition
		for (int code = 0; code < 4; code++) begin
			wr(ctrlAddr(1), ON | (word_t'(code) << `EDGE_LSB));
			base = evtCount;
			setRaw(1'b0);
			waitC(8);
			wr(ctrlAddr(1) + 9'h004, EVT);
			setRaw(1'b1);
			waitC(8);
			wr(ctrlAddr(1) + 9'h004, EVT);
			check(evtCount - base, (code == 0) ? 32'h0 : (code == 3) ? 32'h2 : 32'h1);
		end
		check(word_t'(cmpOutPinOe[1]), 32'h00000000);
		// inverted polarity
		wr(ctrlAddr(1), ON | INV);
		waitC(8);
		check(word_t'(cmpOutPin[1]), 32'h00000000);
		setRaw(1'b0);
		waitC(8);
		rd(`STATUS_OFS, v);
		check(v, 32'h00000002);
		// idle stop freezes, clear keeps running
		wr(`STATUS_OFS, 32'h00002000);
		idleMode <= 1'b1;
		waitC(2);
		check(word_t'(cmpEnable[1]), 32'h00000000);
		setRaw(1'b1);
		waitC(8);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		idleMode <= 1'b0;
		waitC(8);
		check(word_t'({cmpEnable[1], cmpOutPin[1]}), 32'h00000002);
		wr(`STATUS_OFS, 32'h00000000);
		idleMode <= 1'b1;
		waitC(2);
		check(word_t'(cmpEnable[1]), 32'h00000001);
		idleMode <= 1'b0;
		// blanking in or and and modes
		wr(`MASK_BASE + 9'h010, 32'h00000001);
		blankSrc <= 4'h1;
		setRaw(1'b0);
		waitC(8);
		check(word_t'(cmpOutPin[1]), 32'h00000000);
		blankSrc <= 4'h0;
		waitC(8);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		wr(`MASK_BASE + 9'h010, 32'h00000103);
		blankSrc <= 4'h1;
		setRaw(1'b1);
		waitC(8);
		check(word_t'(cmpOutPin[1]), 32'h00000000);
		blankSrc <= 4'h0;
		// digital filter rejects a one-cycle glitch while it passes through
		wr(ctrlAddr(1), ON | FEN);
		waitC(12);
		setRaw(1'b0);
		setRaw(1'b1);
		waitC(2);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		waitC(10);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		// divide by 128: three samples need more than 256 cycles
		wr(ctrlAddr(1), ON | FEN | (32'h7 << `FILT_DIV_LSB));
		setRaw(1'b0);
		waitC(228);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		waitC(200);
		check(word_t'(cmpOutPin[1]), 32'h00000000);
		// slower tick source stretches the filter delay
		wr(ctrlAddr(1), ON | FEN | (32'h1 << `FILT_SEL_LSB));
		setRaw(1'b1);
		waitC(7);
		check(word_t'(cmpOutPin[1]), 32'h00000000);
		waitC(10);
		check(word_t'(cmpOutPin[1]), 32'h00000001);
		conclude();
	end
endmodule : tb_top
